// ===== logic/otx_ctrl.sv
// Purpose: transmitter shutdown, fault latch and two-wire memories of an optical module
// Assumes: scl/sda, shutdown, fault, unsafe and lost pins are asynchronous
// Notes:   sda is open drain; sda_oe_n_out low means the module pulls sda low
//
// Overview of operation
// - answer at device address a0 with a 256-byte identification memory
// - answer at device address a2 with a separate 256-byte diagnostic memory
// - address b0 is reserved; the module never acknowledges it
// - temperature, supply, bias, tx power and rx power are readable live
// - shutdown pin high turns the transmitter off, low lets it run
// - shutdown pin reads as high until the host drives it low
// - software sets bit 6 of byte 110 to request shutdown
// - bit 7 of byte 110 reads the current shutdown control state
// - effective shutdown is pin OR software bit
// - a laser fault raises the fault output and turns the laser off
// - the fault stays latched until shutdown is toggled or power cycles
// - bit 2 of byte 110 mirrors the fault
// - cycling the shutdown control clears the fault and resumes operation
// - eye-safety monitor disables the transmitter while output is unsafe
// - shutdown and signal-loss status are mirrored in the diagnostic memory
// - signal loss reads as bit 1 of byte 110 at address a2
// - signal-lost output is high with unusable input, low with good input
`include "otx_params.svh"
`default_nettype none

module otx_ctrl
  import otx_pkg::*;
(
  // clock, reset, enable
  input  wire logic     clk_sys_in,
  input  wire logic     rst_in,
  input  wire logic     ce_in,
  // two-wire serial bus
  input  wire logic     scl_in,
  input  wire logic     sda_in,
  output logic          sda_out,
  output logic          sda_oe_n_out,
  // host control pins
  input  wire logic     tx_disable_in,
  output logic          tx_fault_out,
  output logic          receive_signal_lost_out,
  // optics side
  input  wire logic     laser_fault_in,
  input  wire logic     eye_unsafe_in,
  input  wire logic     receive_signal_lost_in,
  input  wire otx_mon_t mon_in,
  output logic          laser_off_out
);

  // two-stage synchronisers plus one history stage for the bus lines
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic       scl_d_reg, sda_d_reg;
  logic [1:0] dis_sync_reg, flt_sync_reg, eye_sync_reg, los_sync_reg;

  // two-wire slave state
  otx_state_t state_reg, ack_ret_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg;
  logic [3:0] cnt_reg;
  logic       diag_sel_reg, rd_dir_reg, mack_reg, sda_drive_reg;

  // control state
  logic       soft_shut_reg, fault_reg, shut_seen_reg, laser_off_reg, lost_reg;

  // memories
  logic [7:0] id_mem  [256];
  logic [7:0] diag_mem[256];

  logic       scl_rise, scl_fall, bus_start, bus_stop, byte_done;
  logic       shut_eff, dev_hit, wr_go, ld_go;
  logic [7:0] rd_byte, ctrl_byte;

  // synchronise every asynchronous input
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      dis_sync_reg <= 2'h3;
      flt_sync_reg <= 2'h0;
      eye_sync_reg <= 2'h0;
      los_sync_reg <= 2'h0;
    end
    else if (ce_in)
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
      dis_sync_reg <= {dis_sync_reg[0], tx_disable_in};
      flt_sync_reg <= {flt_sync_reg[0], laser_fault_in};
      eye_sync_reg <= {eye_sync_reg[0], eye_unsafe_in};
      los_sync_reg <= {los_sync_reg[0], receive_signal_lost_in};
    end
  end

  // bus events seen on the synchronised lines
  assign scl_rise  = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall  = ~scl_sync_reg[1] & scl_d_reg;
  assign bus_start = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  assign bus_stop  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
  assign byte_done = scl_fall & (cnt_reg == 4'h8);

  // address match; reserved page and all others stay silent
  assign dev_hit = (shift_reg[7:1] == 7'(`OTX_DEV_ID >> 1))
                 | (shift_reg[7:1] == 7'(`OTX_DEV_DIAG >> 1));

  // data byte write pulse and read byte load pulse
  assign wr_go = (state_reg == ST_WRITE) & byte_done;
  assign ld_go = scl_fall & (((state_reg == ST_ACK) & (ack_ret_reg == ST_READ))
               | ((state_reg == ST_MACK) & mack_reg));

  // effective shutdown of the transmitter
  assign shut_eff = dis_sync_reg[1] | soft_shut_reg;

  // control and status byte as seen by the host
  always_comb
  begin
    ctrl_byte = 8'h00;
    ctrl_byte[`OTX_BIT_SHUT_STAT] = shut_eff;
    ctrl_byte[`OTX_BIT_SOFT_SHUT] = soft_shut_reg;
    ctrl_byte[`OTX_BIT_FAULT]     = fault_reg;
    ctrl_byte[`OTX_BIT_LOST]      = lost_reg;
  end

  // byte returned for the current pointer
  always_comb
  begin
    logic [79:0] mon_bits;
    mon_bits = mon_in;
    rd_byte  = diag_sel_reg ? diag_mem[ptr_reg] : id_mem[ptr_reg];
    if (diag_sel_reg)
    begin
      for (int i = 0; i < `OTX_MON_BYTES; i++)
      begin
        if (ptr_reg == `OTX_MON_OFS + 8'(i))
          rd_byte = mon_bits[79 - 8 * i -: 8];
      end
      if (ptr_reg == `OTX_CTRL_OFS)
        rd_byte = ctrl_byte;
    end
  end

  // two-wire slave sequencing
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_reg    <= ST_IDLE;
      ack_ret_reg  <= ST_IDLE;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      cnt_reg      <= 4'h0;
      diag_sel_reg <= 1'b0;
      rd_dir_reg   <= 1'b0;
      mack_reg     <= 1'b0;
    end
    else if (ce_in)
    begin
      if (bus_start)
      begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
      end
      else if (bus_stop)
        state_reg <= ST_IDLE;
      else
      begin
        if (ld_go)
        begin
          tx_reg  <= rd_byte;
          ptr_reg <= ptr_reg + 8'h01;
        end
        unique case (state_reg)
          ST_IDLE: ;
          ST_ADDR, ST_WORD, ST_WRITE:
          begin
            if (scl_rise && cnt_reg != 4'h8)
            begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              cnt_reg   <= cnt_reg + 4'h1;
            end
            else if (byte_done)
            begin
              state_reg <= ST_ACK;
              if (state_reg == ST_ADDR)
              begin
                if (!dev_hit)
                  state_reg <= ST_IDLE;
                diag_sel_reg <= shift_reg[1];
                rd_dir_reg   <= shift_reg[0];
                ack_ret_reg  <= shift_reg[0] ? ST_READ : ST_WORD;
              end
              else if (state_reg == ST_WORD)
              begin
                ptr_reg     <= shift_reg;
                ack_ret_reg <= ST_WRITE;
              end
              else
              begin
                ptr_reg     <= ptr_reg + 8'h01;
                ack_ret_reg <= ST_WRITE;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              state_reg <= ack_ret_reg;
              cnt_reg   <= 4'h0;
            end
          end
          ST_READ:
          begin
            if (scl_fall)
            begin
              if (cnt_reg == 4'h7)
                state_reg <= ST_MACK;
              else
              begin
                tx_reg  <= {tx_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
              mack_reg <= ~sda_sync_reg[1];
            else if (scl_fall)
            begin
              state_reg <= mack_reg ? ST_READ : ST_IDLE;
              cnt_reg   <= 4'h0;
            end
          end
        endcase
      end
    end
  end

  // open-drain drive: acknowledge slot or outgoing data zero
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      sda_drive_reg <= 1'b0;
    else if (ce_in)
    begin
      if (bus_start || bus_stop)
        sda_drive_reg <= 1'b0;
      else if (byte_done && (state_reg inside {ST_ADDR, ST_WORD, ST_WRITE}))  // ack only after a received byte
        sda_drive_reg <= (state_reg != ST_ADDR) | dev_hit;
      else if (ld_go)
        sda_drive_reg <= ~rd_byte[7];
      else if (scl_fall && state_reg == ST_READ)
        sda_drive_reg <= (cnt_reg == 4'h7) ? 1'b0 : ~tx_reg[6];
      else if (scl_fall && state_reg == ST_ACK)
        sda_drive_reg <= 1'b0;
    end
  end

  // host writes into the memories; live bytes are read only
  always_ff @(posedge clk_sys_in)
  begin
    if (ce_in && wr_go)
    begin
      if (!diag_sel_reg)
        id_mem[ptr_reg] <= shift_reg;
      else
        diag_mem[ptr_reg] <= shift_reg;
    end
  end

  // software shutdown request
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      soft_shut_reg <= `OTX_SOFT_RST;
    else if (ce_in && wr_go && diag_sel_reg && ptr_reg == `OTX_CTRL_OFS)
      soft_shut_reg <= shift_reg[`OTX_BIT_SOFT_SHUT];
  end

  // fault latch, cleared by a full assert-release of shutdown; a new fault wins
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      fault_reg     <= 1'b0;
      shut_seen_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (flt_sync_reg[1])
        fault_reg <= 1'b1;
      else if (fault_reg && shut_seen_reg && !shut_eff)
        fault_reg <= 1'b0;
      shut_seen_reg <= fault_reg & (shut_seen_reg | shut_eff) & ~flt_sync_reg[1]
                     & ~(shut_seen_reg & ~shut_eff);
    end
  end

  // laser enable and status pins
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      laser_off_reg <= 1'b1;
      lost_reg      <= 1'b0;
    end
    else if (ce_in)
    begin
      laser_off_reg <= shut_eff | fault_reg | flt_sync_reg[1]
                     | eye_sync_reg[1];
      lost_reg      <= los_sync_reg[1];
    end
  end

  assign sda_out                 = 1'b0;
  assign sda_oe_n_out            = ~sda_drive_reg;
  assign tx_fault_out            = fault_reg;
  assign receive_signal_lost_out = lost_reg;
  assign laser_off_out           = laser_off_reg;

endmodule : otx_ctrl

`default_nettype wire

// ===== logic/otx_params.svh
// Purpose: constants for the optical module control and status block
// Assumes: 100 MHz system clock
// Notes:   offsets are byte offsets inside a 256-byte two-wire memory
`ifndef OTX_PARAMS_SVH
`define OTX_PARAMS_SVH

// two-wire device addresses (8-bit form, write direction)
`define OTX_DEV_ID        8'ha0
`define OTX_DEV_DIAG      8'ha2
`define OTX_DEV_RSVD      8'hb0

// control and status byte in the diagnostic memory
`define OTX_CTRL_OFS      8'h6e
`define OTX_BIT_SHUT_STAT 7
`define OTX_BIT_SOFT_SHUT 6
`define OTX_BIT_FAULT     2
`define OTX_BIT_LOST      1
`define OTX_SOFT_RST      1'b0

// live monitor values, big endian, ten bytes from this offset
`define OTX_MON_OFS       8'h60
`define OTX_MON_BYTES     10

`endif

// ===== logic/otx_pkg.sv
// Purpose: types for the optical module control and status block
// Assumes: constants live in otx_params.svh
// Notes:   monitor words are raw 16-bit conversion results
`default_nettype none

package otx_pkg;

  // live analog readings, each a 16-bit word
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] tx_pwr;
    logic [15:0] rx_pwr;
  } otx_mon_t;

  // two-wire slave states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ADDR  = 7'b0000010,
    ST_WORD  = 7'b0000100,
    ST_WRITE = 7'b0001000,
    ST_ACK   = 7'b0010000,
    ST_READ  = 7'b0100000,
    ST_MACK  = 7'b1000000
  } otx_state_t;

endpackage : otx_pkg

`default_nettype wire

// ===== verification/otx_ctrl_monitor.sv
// Purpose: port checker for otx_ctrl
// Assumes: ce_in held high by the bench
// Notes:   bound to every otx_ctrl below
`default_nettype none
module otx_ctrl_monitor (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // watched pins
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic tx_disable_in,
  input wire logic tx_fault_out,
  input wire logic laser_fault_in,
  input wire logic eye_unsafe_in,
  input wire logic receive_signal_lost_in,
  input wire logic receive_signal_lost_out,
  input wire logic laser_off_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // causes held long enough to pass the sync path
  sequence s_shut; tx_disable_in[*5]; endsequence
  sequence s_eye; eye_unsafe_in[*5]; endsequence
  sequence s_fail; laser_fault_in[*5]; endsequence
  sequence s_lost; $stable(receive_signal_lost_in)[*4]; endsequence
  property p_rst;
    disable iff (1'b0) rst_in |=> laser_off_out && !tx_fault_out && sda_oe_n_out;
  endproperty
  property p_shut; s_shut |-> laser_off_out; endproperty
  property p_eye; s_eye |-> laser_off_out; endproperty
  property p_fset; s_fail |-> tx_fault_out; endproperty
  property p_foff; tx_fault_out |=> laser_off_out; endproperty
  property p_latch; tx_fault_out && tx_disable_in |=> tx_fault_out; endproperty
  property p_lost; s_lost |-> receive_signal_lost_out == receive_signal_lost_in; endproperty
  property p_sda; !$stable(sda_oe_n_out) |-> !scl_in; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_shut: assert property (p_shut) else $error("pin did not stop laser");
  a_eye: assert property (p_eye) else $error("unsafe did not stop laser");
  a_fset: assert property (p_fset) else $error("fault not raised");
  a_foff: assert property (p_foff) else $error("laser on during fault");
  a_latch: assert property (p_latch) else $error("fault cleared early");
  a_lost: assert property (p_lost) else $error("lost out wrong");
  a_sda: assert property (p_sda) else $error("sda moved with scl high");
endmodule : otx_ctrl_monitor
bind otx_ctrl otx_ctrl_monitor u_mon (.clk_sys_in, .rst_in, .scl_in, .sda_oe_n_out,
  .tx_disable_in, .tx_fault_out, .laser_fault_in, .eye_unsafe_in,
  .receive_signal_lost_in, .receive_signal_lost_out, .laser_off_out);
`default_nettype wire

// ===== verification/otx_host_model.sv
// Purpose: host two-wire master for the optical module
// Assumes: sda_in is the wired-and bus level
// Notes:   scl phases are 16 clocks (8 low before a repeated start), far above the slave minimum
`default_nettype none
module otx_host_model (
  // clock
  input  wire logic clk_in,
  // bus lines
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles released high
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // eight clocks, moved at the falling edge
  task automatic hp();
    repeat (8) @(negedge clk_in);
  endtask : hp
  // start or repeated start, ends with scl low
  task automatic start();
    sda_out = 1'b1; hp(); scl_out = 1'b1; hp(); sda_out = 1'b0; hp(); scl_out = 1'b0;
  endtask : start
  // stop, leaves the bus released
  task automatic stop();
    hp(); sda_out = 1'b0; hp(); scl_out = 1'b1; hp(); sda_out = 1'b1; hp();
  endtask : stop
  // nine bits out, bus level read back on each
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      hp(); sda_out = tx[i]; hp(); scl_out = 1'b1; hp(); hp();
      rx = {rx[7:0], sda_in};
      scl_out = 1'b0;
    end
  endtask : xfer
endmodule : otx_host_model
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: self-checking bench for otx_ctrl
// Assumes: host model drives scl and sda
// Notes:   pins move at the falling edge
`default_nettype none
module testbench;
  import otx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in, rst_in, ce_in, scl, host_sda, sda_o, sda_oe_n;
  logic tx_dis, fault, lost_out, lfault, unsafe, lost_in, laser_off;
  otx_mon_t mon;
  int error_cnt, tests_run;
  logic [8:0] r;
  logic [7:0] v;
  wire sda_line = host_sda & (sda_oe_n | sda_o); // pulled-up open drain
  otx_host_model host (.clk_in(clk_sys_in), .sda_in(sda_line), .scl_out(scl),
    .sda_out(host_sda));
  otx_ctrl dut (.clk_sys_in, .rst_in, .ce_in, .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .tx_disable_in(tx_dis),
    .tx_fault_out(fault), .receive_signal_lost_out(lost_out), .laser_fault_in(lfault),
    .eye_unsafe_in(unsafe), .receive_signal_lost_in(lost_in), .mon_in(mon),
    .laser_off_out(laser_off));
  // 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc
  task automatic wr(input logic [7:0] d, input logic [7:0] o, input logic [7:0] x);
    host.start();
    host.xfer({d, 1'b1}, r); chk(r[0], 8'h00);
    host.xfer({o, 1'b1}, r); chk(r[0], 8'h00);
    host.xfer({x, 1'b1}, r); chk(r[0], 8'h00);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] d, input logic [7:0] o, input logic [7:0] x);
    host.start();
    host.xfer({d, 1'b1}, r); chk(r[0], 8'h00);
    host.xfer({o, 1'b1}, r); chk(r[0], 8'h00);
    host.start();
    host.xfer({d | 8'h01, 1'b1}, r); chk(r[0], 8'h00);
    host.xfer(9'h1ff, r); chk(r[8:1], x);
    host.stop();
  endtask : rd
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // pin, software bit and their or
  task automatic t_shut();
    chk(laser_off, 1); chk(fault, 0);
    rd(8'ha2, 8'h6e, 8'h80);
    tx_dis = 1'b0; cyc(5); chk(laser_off, 0);
    wr(8'ha2, 8'h6e, 8'h40); cyc(3); chk(laser_off, 1);
    rd(8'ha2, 8'h6e, 8'hc0);
    wr(8'ha2, 8'h6e, 8'h00); cyc(3); chk(laser_off, 0);
    rd(8'ha2, 8'h6e, 8'h00);
    $display("shutdown test done");
  endtask : t_shut
  // latched fault cleared by a full pin cycle; the pin is asserted once only
  task automatic t_fault();
    lfault = 1'b1; cyc(5); lfault = 1'b0; cyc(20);
    chk(fault, 1); chk(laser_off, 1);
    rd(8'ha2, 8'h6e, 8'h04); chk(fault, 1);
    tx_dis = 1'b1; cyc(10); chk(fault, 1);
    tx_dis = 1'b0; cyc(10); chk(fault, 0); chk(laser_off, 0);
    unsafe = 1'b1; cyc(5); chk(laser_off, 1); chk(fault, 0);
    unsafe = 1'b0; cyc(5); chk(laser_off, 0);
    lost_in = 1'b1; cyc(5); chk(lost_out, 1);
    rd(8'ha2, 8'h6e, 8'h02); lost_in = 1'b0;
    $display("fault test done");
  endtask : t_fault
  // both memories, live words, reserved page
  task automatic t_mem();
    wr(8'ha0, 8'h10, 8'h5a); wr(8'ha2, 8'h10, 8'ha5);
    rd(8'ha0, 8'h10, 8'h5a);
    rd(8'ha2, 8'h10, 8'ha5);
    rd(8'ha2, 8'h60, 8'h12); rd(8'ha2, 8'h69, 8'h0a);
    host.start(); host.xfer(9'h161, r); chk(r[0], 1); host.stop();
    $display("memory test done");
  endtask : t_mem
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk_sys_in);
    $display("ERROR %0t run timed out", $time);
    error_cnt++;
    test_done();
  end
  // main sequence
  initial
  begin
    error_cnt = 0; tests_run = 0; rst_in = 1'b1; ce_in = 1'b1; tx_dis = 1'b1;
    lfault = 1'b0; unsafe = 1'b0; lost_in = 1'b0;
    mon = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h010a};
    cyc(12); rst_in = 1'b0; cyc(5);
    t_shut(); t_fault(); t_mem();
    test_done();
  end
endmodule : testbench
`default_nettype wire
